// ==== hw/ppid_defines.svh ====
// Offsets, reset values and timing counts of the process regulator.
`ifndef PPID_DEFINES_SVH
`define PPID_DEFINES_SVH
`define PPID_CLK_HZ 10000000
`define PPID_SAMPLE_US 1000
`define PPID_SAMPLE_CYC ((`PPID_CLK_HZ / 1000000) * `PPID_SAMPLE_US)
`define PPID_SPS (1000000 / `PPID_SAMPLE_US)
`define PPID_TENTH_SAMPLES (`PPID_SPS / 10)
`define PPID_FULL_PCT 1000
`define PPID_GAIN_ONE 100
`define PPID_OFF_CTRL 8'h00
`define PPID_OFF_MAXF 8'h04
`define PPID_OFF_VLO 8'h08
`define PPID_OFF_VHI 8'h0c
`define PPID_OFF_CLO 8'h10
`define PPID_OFF_CHI 8'h14
`define PPID_OFF_STAT0 8'h18
`define PPID_OFF_STAT1 8'h1c
`define PPID_SET_BASE0 8'h40
`define PPID_SET_BASE1 8'h80
`define PPID_SOFF_SEL 8'h00
`define PPID_SOFF_SETPT 8'h04
`define PPID_SOFF_DBAND 8'h08
`define PPID_SOFF_PRELD 8'h0c
`define PPID_SOFF_UPLIM 8'h10
`define PPID_SOFF_LOLIM 8'h14
`define PPID_SOFF_KP 8'h18
`define PPID_SOFF_TI 8'h1c
`define PPID_SOFF_KD 8'h20
`define PPID_SEL_TRIM_BIT 16
`define PPID_RST_MAXF 16'h0258
`define PPID_RST_PCT_HI 16'h03e8
`define PPID_RST_UPLIM 16'h0258
`define PPID_RST_LOLIM 16'hfda8
`define PPID_RST_KP 16'h0064
`define PPID_RST_TI 16'h0014
`define PPID_RST_KD 16'h0000
`endif

// ==== hw/ppid_pkg.sv ====
// Types shared by the process regulator.
package ppid_pkg;
    typedef logic signed [15:0] ppid_val_type;
    typedef enum logic [1:0] {
        PPID_SRC_SETPT,
        PPID_SRC_VOLT,
        PPID_SRC_CURR,
        PPID_SRC_NET
    } ppid_src_type;
endpackage

// ==== hw/ppid_regulator.sv ====
// Process regulator: input scaling, deadband, PID terms, limits and command.
`timescale 1ns/100ps
`include "ppid_defines.svh"
// Notes on behaviour
// - Analog input maps linearly between programmable low and high points.
// - Low point above high point inverts the current-loop input scaling.
// - Errors within the deadband either side of the reference are ignored.
// - Start or enable loads the preload frequency into the integral.
// - Output limits apply only in trim mode, never in exclusive mode.
// - Trim mode clamps output to upper forward and lower reverse limits.
// - Integral stops updating while output sits at a limit.
// - Proportional term is gain times error; gain 1 gives 100% per 100%.
// - Proportional gain 0.00 forces the proportional term to zero.
// - Integral reaches 100% after 100% error held for integral time.
// - Integral time 0.0 disables the integral term.
// - Differential term is gain times change of error between updates.
// - Gain 1.00 gives 0.1% of maximum per 1%/s error change.
// - Differential gain 0.00, the reset default, disables that term.
// - Error is reference minus feedback.
// - Two parameter sets are held; exactly one is active.
// - Trim adds output to speed reference; exclusive uses output alone.
module ppid_regulator
    import ppid_pkg::*;
#(
    parameter int SAMPLE_CYC = `PPID_SAMPLE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Process inputs, percent in 0.1 units, frequency in 0.1 Hz
    input wire logic [10:0] volt_input_in,
    input wire logic [10:0] current_input_in,
    input wire logic signed [15:0] net_reference_in,
    input wire logic signed [15:0] net_feedback_in,
    input wire logic signed [15:0] speed_ref_in,
    input wire logic run_in,
    // Command outputs
    output logic signed [15:0] freq_cmd_out,
    output logic signed [15:0] pid_out_out,
    output logic pid_active_out,
    output logic at_limit_out
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic ppid_val_type sat16(input logic signed [31:0] x);
        if (x > 32'sd32767) begin
            sat16 = 16'sh7fff;
        end else if (x < -32'sd32768) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = x[15:0];
        end
    endfunction

    // Points are percent of the raw range; a low point above high inverts.
    function automatic ppid_val_type scale_in(input logic [10:0] raw,
                                              input ppid_val_type lo,
                                              input ppid_val_type hi);
        logic signed [31:0] r;
        r = 32'sd0;
        if (hi != lo) begin
            r = ((32'($signed({1'b0, raw})) - 32'(lo)) * `PPID_FULL_PCT)
                / (32'(hi) - 32'(lo));
        end
        if (r < 32'sd0) begin
            r = 32'sd0;
        end else if (r > `PPID_FULL_PCT) begin
            r = `PPID_FULL_PCT;
        end
        scale_in = r[15:0];
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic en_ff;
    logic set_ff;
    ppid_val_type maxf_ff;
    ppid_val_type vlo_ff;
    ppid_val_type vhi_ff;
    ppid_val_type clo_ff;
    ppid_val_type chi_ff;
    logic [1:0] rsel_ff [2];
    logic [1:0] fsel_ff [2];
    logic trim_ff [2];
    ppid_val_type setpt_ff [2];
    ppid_val_type dband_ff [2];
    ppid_val_type preld_ff [2];
    ppid_val_type uplim_ff [2];
    ppid_val_type lolim_ff [2];
    logic [15:0] kp_ff [2];
    logic [15:0] ti_ff [2];
    logic [15:0] kd_ff [2];
    logic [7:0] set_base [2];
    assign set_base[0] = `PPID_SET_BASE0;
    assign set_base[1] = `PPID_SET_BASE1;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            en_ff <= 1'b0;
            set_ff <= 1'b0;
            maxf_ff <= `PPID_RST_MAXF;
            vlo_ff <= 16'sh0000;
            vhi_ff <= `PPID_RST_PCT_HI;
            clo_ff <= 16'sh0000;
            chi_ff <= `PPID_RST_PCT_HI;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, `PPID_OFF_CTRL)) begin
                en_ff <= reg_wdata_in[0];
                set_ff <= reg_wdata_in[1];
            end
            if (hit(reg_addr_in, `PPID_OFF_MAXF)) begin
                maxf_ff <= reg_wdata_in[15:0];
            end
            if (hit(reg_addr_in, `PPID_OFF_VLO)) begin
                vlo_ff <= reg_wdata_in[15:0];
            end
            if (hit(reg_addr_in, `PPID_OFF_VHI)) begin
                vhi_ff <= reg_wdata_in[15:0];
            end
            if (hit(reg_addr_in, `PPID_OFF_CLO)) begin
                clo_ff <= reg_wdata_in[15:0];
            end
            if (hit(reg_addr_in, `PPID_OFF_CHI)) begin
                chi_ff <= reg_wdata_in[15:0];
            end
        end
    end

    // Two independent parameter sets.
    for (genvar s = 0; s < 2; s++) begin : g_set
        always_ff @(posedge mclk_in) begin
            if (!rst_b_in) begin
                rsel_ff[s] <= PPID_SRC_SETPT;
                fsel_ff[s] <= 2'h1;
                trim_ff[s] <= 1'b0;
                setpt_ff[s] <= 16'sh0000;
                dband_ff[s] <= 16'sh0000;
                preld_ff[s] <= 16'sh0000;
                uplim_ff[s] <= `PPID_RST_UPLIM;
                lolim_ff[s] <= `PPID_RST_LOLIM;
                kp_ff[s] <= `PPID_RST_KP;
                ti_ff[s] <= `PPID_RST_TI;
                kd_ff[s] <= `PPID_RST_KD;
            end else if (reg_wr_in) begin
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_SEL)) begin
                    rsel_ff[s] <= reg_wdata_in[1:0];
                    fsel_ff[s] <= reg_wdata_in[9:8];
                    trim_ff[s] <= reg_wdata_in[`PPID_SEL_TRIM_BIT];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_SETPT)) begin
                    setpt_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_DBAND)) begin
                    dband_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_PRELD)) begin
                    preld_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_UPLIM)) begin
                    uplim_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_LOLIM)) begin
                    lolim_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_KP)) begin
                    kp_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_TI)) begin
                    ti_ff[s] <= reg_wdata_in[15:0];
                end
                if (hit(reg_addr_in, set_base[s] + `PPID_SOFF_KD)) begin
                    kd_ff[s] <= reg_wdata_in[15:0];
                end
            end
        end
    end

    // ****************************************
    // Error formation
    // ****************************************
    ppid_val_type volt_pct;
    ppid_val_type curr_pct;
    ppid_val_type ref_pct;
    ppid_val_type fb_pct;
    ppid_val_type err_now;
    logic signed [16:0] err_raw;
    logic signed [16:0] err_abs;

    assign volt_pct = scale_in(volt_input_in, vlo_ff, vhi_ff);
    assign curr_pct = scale_in(current_input_in, clo_ff, chi_ff);

    always_comb begin
        case (rsel_ff[set_ff])
            PPID_SRC_SETPT: ref_pct = setpt_ff[set_ff];
            PPID_SRC_VOLT: ref_pct = volt_pct;
            PPID_SRC_CURR: ref_pct = curr_pct;
            default: ref_pct = net_reference_in;
        endcase
        case (fsel_ff[set_ff])
            2'h1: fb_pct = volt_pct;
            2'h2: fb_pct = curr_pct;
            2'h3: fb_pct = net_feedback_in;
            default: fb_pct = volt_pct;
        endcase
        err_raw = 17'(ref_pct) - 17'(fb_pct);
        err_abs = err_raw[16] ? -err_raw : err_raw;
        if (err_abs <= 17'(dband_ff[set_ff])) begin
            err_now = 16'sh0000;
        end else begin
            err_now = sat16(32'(err_raw));
        end
    end

    // ****************************************
    // Sample timing and start detection
    // ****************************************
    logic [15:0] tick_cnt_ff;
    logic calc_ff;
    logic act_d_ff;
    logic active;
    logic start;
    ppid_val_type err_ff;
    ppid_val_type prev_ff;

    assign active = en_ff & run_in;
    assign start = active & ~act_d_ff;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            tick_cnt_ff <= 16'h0000;
            calc_ff <= 1'b0;
            err_ff <= 16'sh0000;
            prev_ff <= 16'sh0000;
        end else begin
            calc_ff <= 1'b0;
            if (tick_cnt_ff == 16'(SAMPLE_CYC - 1)) begin
                tick_cnt_ff <= 16'h0000;
                err_ff <= err_now;
                prev_ff <= err_ff;
                calc_ff <= active;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            act_d_ff <= 1'b0;
        end else begin
            act_d_ff <= active;
        end
    end

    // ****************************************
    // PID terms and limits
    // ****************************************
    logic signed [31:0] acc_ff;
    logic sat_ff;
    logic signed [31:0] i_div;
    logic signed [31:0] p_term;
    logic signed [31:0] i_term;
    logic signed [31:0] d_term;
    logic signed [31:0] sum_pct;
    logic signed [31:0] out_hz;
    logic signed [31:0] pre_acc;
    ppid_val_type lim_out;
    logic lim_hit;
    logic trim;

    assign trim = trim_ff[set_ff];
    assign i_div = $signed({16'h0000, ti_ff[set_ff]}) * `PPID_TENTH_SAMPLES;

    always_comb begin
        p_term = 32'sd0;
        i_term = 32'sd0;
        if (kp_ff[set_ff] != 16'h0000) begin
            p_term = ($signed({16'h0000, kp_ff[set_ff]}) * 32'(err_ff))
                     / `PPID_GAIN_ONE;
        end
        if (ti_ff[set_ff] != 16'h0000) begin
            i_term = acc_ff / i_div;
        end
        // Scaled to the sample rate so the gain does not move with it.
        d_term = ($signed({16'h0000, kd_ff[set_ff]}) * (32'(err_ff) - 32'(prev_ff))
                  * `PPID_SPS) / 1000;
        sum_pct = p_term + i_term + d_term;
        out_hz = (sum_pct * 32'(maxf_ff)) / `PPID_FULL_PCT;
        lim_hit = 1'b0;
        lim_out = sat16(out_hz);
        if (trim) begin
            if (out_hz >= 32'(uplim_ff[set_ff])) begin
                lim_out = uplim_ff[set_ff];
                lim_hit = 1'b1;
            end else if (out_hz <= 32'(lolim_ff[set_ff])) begin
                lim_out = lolim_ff[set_ff];
                lim_hit = 1'b1;
            end
        end
        pre_acc = 32'sd0;
        if (maxf_ff != 16'sh0000) begin
            pre_acc = ((32'(preld_ff[set_ff]) * `PPID_FULL_PCT) / 32'(maxf_ff)) * i_div;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            acc_ff <= 32'sd0;
        end else if (start) begin
            acc_ff <= pre_acc;
        end else if (calc_ff && ti_ff[set_ff] != 16'h0000 && !sat_ff) begin
            acc_ff <= acc_ff + 32'(err_ff);
        end
    end

    // ****************************************
    // Command outputs
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pid_out_out <= 16'sh0000;
            freq_cmd_out <= 16'sh0000;
            sat_ff <= 1'b0;
            at_limit_out <= 1'b0;
            pid_active_out <= 1'b0;
        end else begin
            pid_active_out <= active;
            if (!active) begin
                // A disabled loop passes the ramped speed reference through.
                freq_cmd_out <= speed_ref_in;
                sat_ff <= 1'b0;
                at_limit_out <= 1'b0;
            end else if (calc_ff) begin
                pid_out_out <= lim_out;
                sat_ff <= lim_hit;
                at_limit_out <= lim_hit;
                if (trim) begin
                    freq_cmd_out <= sat16(32'(speed_ref_in) + 32'(lim_out));
                end else begin
                    freq_cmd_out <= lim_out;
                end
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [31:0] rd_mux;
    logic [7:0] soff;
    logic sidx;

    always_comb begin
        rd_mux = 32'h0000_0000;
        sidx = reg_addr_in[7];
        soff = reg_addr_in - set_base[sidx];
        case (reg_addr_in)
            `PPID_OFF_CTRL: rd_mux = {30'h0, set_ff, en_ff};
            `PPID_OFF_MAXF: rd_mux = {16'h0, maxf_ff};
            `PPID_OFF_VLO: rd_mux = {16'h0, vlo_ff};
            `PPID_OFF_VHI: rd_mux = {16'h0, vhi_ff};
            `PPID_OFF_CLO: rd_mux = {16'h0, clo_ff};
            `PPID_OFF_CHI: rd_mux = {16'h0, chi_ff};
            `PPID_OFF_STAT0: rd_mux = {pid_out_out, err_ff};
            `PPID_OFF_STAT1: rd_mux = {freq_cmd_out, 14'h0, at_limit_out, pid_active_out};
            default: rd_mux = 32'h0000_0000;
        endcase
        if (reg_addr_in[7:6] == 2'h1 || reg_addr_in[7:6] == 2'h2) begin
            case (soff)
                `PPID_SOFF_SEL: rd_mux = {15'h0, trim_ff[sidx], 6'h0, fsel_ff[sidx],
                                         6'h0, rsel_ff[sidx]};
                `PPID_SOFF_SETPT: rd_mux = {16'h0, setpt_ff[sidx]};
                `PPID_SOFF_DBAND: rd_mux = {16'h0, dband_ff[sidx]};
                `PPID_SOFF_PRELD: rd_mux = {16'h0, preld_ff[sidx]};
                `PPID_SOFF_UPLIM: rd_mux = {16'h0, uplim_ff[sidx]};
                `PPID_SOFF_LOLIM: rd_mux = {16'h0, lolim_ff[sidx]};
                `PPID_SOFF_KP: rd_mux = {16'h0, kp_ff[sidx]};
                `PPID_SOFF_TI: rd_mux = {16'h0, ti_ff[sidx]};
                `PPID_SOFF_KD: rd_mux = {16'h0, kd_ff[sidx]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule

// ==== dv/ppid_sensor_model.sv ====
// Process sensor model feeding the analog readings of the regulator.
`timescale 1ns/100ps
module ppid_sensor_model (
    // Clock
    input wire logic mclk_in,
    // Process levels
    input wire logic [10:0] volt_level_in,
    input wire logic [10:0] curr_level_in,
    // Converted readings
    output logic [10:0] volt_input_out,
    output logic [10:0] current_input_out
);
    // A real converter never answers in the cycle it is asked, so one cycle of delay.
    always_ff @(posedge mclk_in) begin
        volt_input_out <= volt_level_in;
        current_input_out <= curr_level_in;
    end
endmodule

// ==== dv/ppid_regulator_sva.sv ====
// Port checks of the process regulator and their bind.
`timescale 1ns/100ps
module ppid_regulator_sva
    import ppid_pkg::*;
#(
    parameter int SAMPLE_CYC = 10000
) (
    // Clock, reset and register port
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Process side
    input wire logic signed [15:0] speed_ref_in,
    input wire logic run_in,
    input wire logic signed [15:0] freq_cmd_out,
    input wire logic signed [15:0] pid_out_out,
    input wire logic pid_active_out,
    input wire logic at_limit_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    int ph_ff;
    // Mirrors the free-running sample counter, so updates can be pinned to one phase.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in || ph_ff == SAMPLE_CYC - 1) begin
            ph_ff <= 0;
        end else begin
            ph_ff <= ph_ff + 1;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_rd_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_unmapped;
        $past(reg_rd_in) && $past(reg_addr_in) == 8'h3c |-> reg_rdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat0;
        $past(reg_rd_in) && $past(reg_addr_in) == 8'h18 |->
            reg_rdata_out[31:16] == $past(pid_out_out);
    endproperty
    a_stat0: assert property (p_stat0) else $error("status output field wrong");
    property p_stat1;
        $past(reg_rd_in) && $past(reg_addr_in) == 8'h1c |-> reg_rdata_out ==
            {$past(freq_cmd_out), 14'h0, $past(at_limit_out), $past(pid_active_out)};
    endproperty
    a_stat1: assert property (p_stat1) else $error("command status word wrong");
    property p_active_run;
        pid_active_out |-> $past(run_in);
    endproperty
    a_active_run: assert property (p_active_run) else $error("active without run");
    property p_follow;
        !pid_active_out ##1 !pid_active_out |-> freq_cmd_out == $past(speed_ref_in);
    endproperty
    a_follow: assert property (p_follow) else $error("idle command not speed ref");
    property p_out_phase;
        pid_active_out && $past(pid_active_out) && $changed(pid_out_out) |-> ph_ff == 1;
    endproperty
    a_out_phase: assert property (p_out_phase) else $error("output off sample");
    property p_cmd_phase;
        pid_active_out && $past(pid_active_out) && $changed(freq_cmd_out) |-> ph_ff == 1;
    endproperty
    a_cmd_phase: assert property (p_cmd_phase) else $error("command off sample");
    property p_reset;
        disable iff (1'b0) !rst_b_in |=> freq_cmd_out == 16'sh0 && pid_out_out == 16'sh0 &&
            !pid_active_out && !at_limit_out && reg_rdata_out == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    c_limit: cover property ($rose(at_limit_out));
    c_start: cover property ($rose(pid_active_out));
    c_update: cover property (pid_active_out && $changed(pid_out_out));
endmodule
bind ppid_regulator ppid_regulator_sva #(.SAMPLE_CYC(SAMPLE_CYC)) u_sva (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .speed_ref_in(speed_ref_in),
    .run_in(run_in), .freq_cmd_out(freq_cmd_out), .pid_out_out(pid_out_out),
    .pid_active_out(pid_active_out), .at_limit_out(at_limit_out)
);

// ==== dv/tb_ppid_regulator.sv ====
// Self-checking bench of the process regulator.
`timescale 1ns/100ps
module tb_ppid_regulator;
    import ppid_pkg::*;
    localparam int SC = 20;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata;
    logic [10:0] vlev = 11'h0;
    logic [10:0] clev = 11'h0;
    logic [10:0] volt;
    logic [10:0] curr;
    ppid_val_type nref = 16'sh0;
    ppid_val_type nfb = 16'sh0;
    ppid_val_type spd = 16'sh0;
    logic run = 1'b0;
    ppid_val_type fcmd;
    ppid_val_type pout;
    logic act;
    logic lim;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int ph = 0;
    int lfsr_ff = 86337;
    int e, x, f, v, c;
    logic [31:0] d;
    logic [7:0] ra [10] = '{8'h04, 8'h0c, 8'h14, 8'h40, 8'h50, 8'h54, 8'h58, 8'h5c,
        8'h60, 8'h3c};
    logic [31:0] rv [10] = '{32'h258, 32'h3e8, 32'h3e8, 32'h100, 32'h258, 32'hfda8,
        32'h64, 32'h14, 32'h0, 32'h0};
    int db [4] = '{-40, -50, -60, 55};
    int tr [3] = '{500, -500, 50};

    ppid_sensor_model sensor_u (.mclk_in(mclk_in), .volt_level_in(vlev),
        .curr_level_in(clev), .volt_input_out(volt), .current_input_out(curr));
    ppid_regulator #(.SAMPLE_CYC(SC)) dut_u (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .volt_input_in(volt),
        .current_input_in(curr), .net_reference_in(nref), .net_feedback_in(nfb),
        .speed_ref_in(spd), .run_in(run), .freq_cmd_out(fcmd), .pid_out_out(pout),
        .pid_active_out(act), .at_limit_out(lim)
    );

    always #50 mclk_in = ~mclk_in;
    // Sample phase, counted like the regulator's own free-running counter.
    always @(posedge mclk_in) begin
        ph <= (!rst_b_in || ph == SC - 1) ? 0 : ph + 1;
        cyc = cyc + 1;
        if (cyc == 10000) begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end

    function automatic int rnd(int m);
        lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
        return (lfsr_ff & 32'h7fffffff) % m;
    endfunction
    function automatic int f_scale(int in, int lo, int hi);
        int r;
        r = (in - lo) * 1000 / (hi - lo);
        return r > 1000 ? 1000 : (r < 0 ? 0 : r);
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] val);
        @(posedge mclk_in);
        addr <= a;
        wdata <= val;
        reg_wr <= 1'b1;
        @(posedge mclk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a);
        @(posedge mclk_in);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk_in);
        reg_rd <= 1'b0;
        @(negedge mclk_in);
        d = rdata;
    endtask
    // Leaves the caller settled just after n regulator updates.
    task automatic upd(int n);
        repeat (n) begin
            @(negedge mclk_in);
            while (ph != 2) @(negedge mclk_in);
        end
    endtask
    task automatic proc(int r, int fb);
        @(posedge mclk_in);
        nref <= 16'(r);
        nfb <= 16'(fb);
    endtask
    // Disabling first makes every configuration a fresh start with its preload.
    task automatic cfg(int sel, int kp, int ti, int kd, int pre);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h40, sel);
        wr_reg(8'h4c, pre);
        wr_reg(8'h58, kp);
        wr_reg(8'h5c, ti);
        wr_reg(8'h60, kd);
        wr_reg(8'h00, 32'h1);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_reg(ra[i]);
            chk(d, rv[i]);
        end
        @(posedge mclk_in);
        run <= 1'b1;
        spd <= 16'(rnd(1001));
        wr_reg(8'h50, 32'd100);
        wr_reg(8'h54, 32'hff9c);
        cfg(32'h303, 100, 0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 500 : (rnd(161) - 80) * 5;
            f = rnd(400);
            proc(f + e, f);
            upd(2);
            rd_reg(8'h18);
            chk(d[15:0], e[15:0]);
            chk(pout, e * 3 / 5);
            chk(fcmd, e * 3 / 5);
        end
        cfg(32'h303, 0, 0, 0, 0);
        upd(2);
        chk(pout, 32'h0);
        wr_reg(8'h44, 32'd250);
        cfg(32'h300, 100, 0, 0, 0);
        wr_reg(8'h48, 32'd50);
        for (int i = 0; i < 4; i++) begin
            e = db[i];
            x = (e > 50 || e < -50) ? e : 0;
            proc(0, 250 - e);
            upd(2);
            rd_reg(8'h18);
            chk(d[15:0], x[15:0]);
        end
        wr_reg(8'h48, 32'd0);
        wr_reg(8'h0c, 32'd500);
        wr_reg(8'h10, 32'd1000);
        wr_reg(8'h14, 32'd0);
        cfg(32'h201, 100, 0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 500 : (i == 1 ? 0 : rnd(1001));
            c = (i == 0) ? 1000 : (i == 1 ? 0 : rnd(1001));
            @(posedge mclk_in);
            vlev <= 11'(v);
            clev <= 11'(c);
            upd(2);
            rd_reg(8'h18);
            x = f_scale(v, 0, 500) - f_scale(c, 1000, 0);
            chk(d[15:0], x[15:0]);
        end
        cfg(32'h10303, 100, 0, 0, 0);
        for (int i = 0; i < 3; i++) begin
            e = tr[i];
            x = e > 166 ? 100 : (e < -166 ? -100 : e * 3 / 5);
            proc(e, 0);
            upd(2);
            rd_reg(8'h1c);
            chk(pout, x);
            chk(d, {16'(spd + x), 14'h0, x == 100 || x == -100, 1'b1});
        end
        wr_reg(8'h50, 32'd60);
        cfg(32'h10303, 0, 1, 0, 0);
        proc(1000, 0);
        upd(60);
        chk(pout, 32'd60);
        wr_reg(8'h50, 32'd600);
        upd(1);
        chk(pout <= 72, 1'b1);
        cfg(32'h303, 0, 1, 0, 0);
        upd(50);
        chk(pout >= 282 && pout <= 312, 1'b1);
        proc(0, 0);
        cfg(32'h303, 0, 20, 0, 300);
        upd(2);
        chk(pout, 32'd300);
        cfg(32'h303, 0, 0, 100, 0);
        upd(2);
        proc(5, 0);
        upd(1);
        chk(pout, 32'd300);
        upd(1);
        chk(pout, 32'h0);
        proc(500, 0);
        wr_reg(8'h80, 32'h303);
        wr_reg(8'h98, 32'd50);
        wr_reg(8'h9c, 32'd0);
        wr_reg(8'h00, 32'h3);
        upd(2);
        chk(pout, 32'd150);
        wr_reg(8'h00, 32'h1);
        upd(2);
        chk(pout, 32'h0);
        @(posedge mclk_in);
        run <= 1'b0;
        upd(1);
        chk(fcmd, spd);
        chk(act, 1'b0);
        @(posedge mclk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd_reg(8'h98);
        chk(d, 32'h64);
        end_of_test();
    end
endmodule
